// ---- logic/wdpa_pkg.sv ----
// Purpose: constants and types of the prescaled autoload watchdog
// Assumes: 32-bit APB, one clock, tick enable from the timer block
// Notes:   register offsets here are byte addresses
//
// Notes on behaviour
// R1: watchdog runs after every reset; software must switch it off explicitly.
// R2: main timer underflow raises a full system reset.
// R3: 13-bit prescaler followed by 8-bit main down-counter.
// R4: prescaler advances on the shared timer tick clock.
// R5: counter decrements on a tap of the top eight bits, fastest every 32 ticks.
// R6: decrement tick at zero gives underflow and reload from autoload.
// R7: autoload value 00 to ff; every autoload clears the prescaler.
// R8: timeout equals tick period times divisor times autoload plus one.
// R9: no direct software write path into the main counter.
// R10: feed is a5 to first feed register then 5a to second.
// R11: any other register access between the two feed writes resets.
// R12: correct first write then wrong second write resets at once.
// R13: control register writes wait pending until a valid feed.
// R14: software stops it by writing zero to control, then feeding.
// R15: software feeds within one timeout period of the last feed.
// R16: select codes 0 to 7 give divisors 32 up to 4096.
// R17: external reset: run on, autoload 00, flag clear, highest divide, autoload.
// R18: underflow: autoload, set flag, keep run, autoload and tap.
// R19: timeout flag stays readable after a watchdog reset; software clears it.
// R20: with run cleared, prescaler and counter hold and nothing resets; the code still resets on a failed feed.
`default_nettype none
package wdpa_pkg;
   // ==========================================================
   // sizes
   localparam int PRE_WIDTH = 13;
   localparam int CNT_WIDTH = 8;
   localparam int SEL_WIDTH = 3;
   localparam int ADDR_WIDTH = 8;
   localparam logic [3:0] TAP_BASE = 4'h5;   // code 0 taps five bits
   // ==========================================================
   // register offsets
   localparam logic [ADDR_WIDTH-1:0] ADDR_CTRL     = 8'h00;
   localparam logic [ADDR_WIDTH-1:0] ADDR_AUTOLOAD = 8'h04;
   localparam logic [ADDR_WIDTH-1:0] ADDR_FEED1    = 8'h08;
   localparam logic [ADDR_WIDTH-1:0] ADDR_FEED2    = 8'h0c;
   localparam logic [ADDR_WIDTH-1:0] ADDR_COUNT    = 8'h10;
   // ==========================================================
   // control register fields
   localparam int CTRL_SEL_LSB = 5;
   localparam int CTRL_RUN_BIT = 2;
   localparam int CTRL_FLAG_BIT = 1;
   // ==========================================================
   // feed keys and reset values
   localparam logic [7:0] FEED1_KEY = 8'ha5;
   localparam logic [7:0] FEED2_KEY = 8'h5a;
   localparam logic [SEL_WIDTH-1:0] RST_SEL = 3'h7;
   localparam logic RST_RUN = 1'b1;
   localparam logic [CNT_WIDTH-1:0] RST_AUTOLOAD = 8'h00;
   // ==========================================================
   // feed sequence states
   typedef enum logic [0:0] {
      WDPA_IDLE  = 1'b0,
      WDPA_ARMED = 1'b1
   } wdpa_feed_state_t;
endpackage
`default_nettype wire

// ---- logic/wdpa_prescaler.sv ----
// Purpose: 13-bit prescaler with selectable decrement tap
// Assumes: tick is a one-cycle enable on pclk
// Notes:   clear wins over counting
`timescale 1ns/1ps
`default_nettype none
module wdpa_prescaler
   import wdpa_pkg::*;
(
   // clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // control
   input  wire logic                 tick,
   input  wire logic                 run,
   input  wire logic                 clear,
   input  wire logic [SEL_WIDTH-1:0] sel,
   // results
   output logic                      dec,
   output logic [PRE_WIDTH-1:0]      pre_count
);
   logic [PRE_WIDTH-1:0] mask;
   logic [3:0]           tap;

   // ==========================================================
   // tap mask: code n watches bits n+4 down to 0
   assign tap = 4'(sel) + TAP_BASE; // R16
   genvar i;
   generate
      for (i = 0; i < PRE_WIDTH; i++) begin : g_mask
         assign mask[i] = (4'(i) < tap);
      end
   endgenerate

   // carry out of the tapped bit, only while running
   assign dec = tick && run && ((pre_count | ~mask) == '1); // R5 R20

   // ==========================================================
   // free count; stands still when stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_count <= '0; // R17
      end else if (clear) begin
         pre_count <= '0; // R7
      end else if (tick && run) begin
         pre_count <= pre_count + 1'b1; // R4 R3
      end
   end
endmodule // wdpa_prescaler
`default_nettype wire

// ---- logic/wdpa_feed_check.sv ----
// Purpose: watches completed register accesses for the feed sequence
// Assumes: acc is high for exactly the completing cycle of an access
// Notes:   a lone wrong first write is simply ignored
`timescale 1ns/1ps
`default_nettype none
module wdpa_feed_check
   import wdpa_pkg::*;
(
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // completed access
   input  wire logic                  acc,
   input  wire logic                  wr,
   input  wire logic [ADDR_WIDTH-1:0] addr,
   input  wire logic [7:0]            wdata,
   // results
   output logic                       feed_ok,
   output logic                       feed_fail
);
   wdpa_feed_state_t state;
   wdpa_feed_state_t next_state;
   logic first_ok;

   // ==========================================================
   // decode of the two keyed writes
   assign first_ok = acc && wr && addr == ADDR_FEED1 && wdata == FEED1_KEY;
   assign feed_ok = state == WDPA_ARMED && acc && wr && addr == ADDR_FEED2
                    && wdata == FEED2_KEY; // R10
   // any other access while armed, or a wrong second key, fails
   assign feed_fail = state == WDPA_ARMED && acc && !feed_ok; // R11 R12

   always_comb begin
      next_state = state;
      case (state)
         WDPA_IDLE: begin
            if (first_ok) next_state = WDPA_ARMED;
         end
         WDPA_ARMED: begin
            if (acc) next_state = WDPA_IDLE; // R10
         end
         default: next_state = WDPA_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= WDPA_IDLE;
      end else begin
         state <= next_state;
      end
   end
endmodule // wdpa_feed_check
`default_nettype wire

// ---- logic/wdpa_top.sv ----
// Purpose: prescaled autoload watchdog with APB register access
// Assumes: timer_tick_clock is a same-clock one-cycle enable
// Notes:   sys_reset_req is a one-cycle request to the reset block
`timescale 1ns/1ps
`default_nettype none
module wdpa_top
   import wdpa_pkg::*;
(
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // apb slave
   input  wire logic [ADDR_WIDTH-1:0] paddr,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // tick shared with the general timers
   input  wire logic                  timer_tick_clock,
   // system side
   output logic                       sys_reset_req,
   output logic                       timeout_flag
);
   // ==========================================================
   // state
   logic [SEL_WIDTH-1:0] pend_sel;
   logic                 pend_run;
   logic [SEL_WIDTH-1:0] act_sel;
   logic                 run_bit;
   logic [CNT_WIDTH-1:0] autoload_reg;
   logic [CNT_WIDTH-1:0] count;

   // ==========================================================
   // events
   logic                 setup;
   logic                 acc;
   logic                 wr;
   logic                 hit;
   logic                 feed_ok;
   logic                 feed_fail;
   logic                 dec;
   logic                 underflow;
   logic                 wd_event;
   logic                 load;
   logic                 flag_clr;
   logic [PRE_WIDTH-1:0] pre_count;
   logic [31:0]          next_rdata;

   // ==========================================================
   // bus phases
   assign setup = psel && !penable;
   assign acc = psel && penable && pready;
   assign wr = acc && pwrite;

   // underflow only exists while running
   assign underflow = dec && count == '0; // R6
   // failed feeds behave exactly like an underflow
   assign wd_event = underflow || feed_fail; // R2 R11 R12
   assign load = feed_ok || wd_event; // R7
   // software clears the flag by writing zero to it
   assign flag_clr = wr && paddr == ADDR_CTRL && !pwdata[CTRL_FLAG_BIT]; // R19

   // ==========================================================
   // submodules
   wdpa_prescaler u_pre (
      .pclk      (pclk),
      .presetn   (presetn),
      .tick      (timer_tick_clock), // R4
      .run       (run_bit),
      .clear     (load),
      .sel       (act_sel),
      .dec       (dec),
      .pre_count (pre_count)
   );

   wdpa_feed_check u_feed (
      .pclk      (pclk),
      .presetn   (presetn),
      .acc       (acc),
      .wr        (pwrite),
      .addr      (paddr),
      .wdata     (pwdata[7:0]),
      .feed_ok   (feed_ok),
      .feed_fail (feed_fail)
   );

   // ==========================================================
   // read mux; unmapped addresses read zero
   always_comb begin
      next_rdata = '0;
      hit = 1'b1;
      case (paddr)
         ADDR_CTRL: begin
            next_rdata[CTRL_SEL_LSB +: SEL_WIDTH] = act_sel;
            next_rdata[CTRL_RUN_BIT] = run_bit;
            next_rdata[CTRL_FLAG_BIT] = timeout_flag;
         end
         ADDR_AUTOLOAD: begin
            next_rdata[CNT_WIDTH-1:0] = autoload_reg;
         end
         ADDR_FEED1: begin
            next_rdata = '0;
         end
         ADDR_FEED2: begin
            next_rdata = '0;
         end
         ADDR_COUNT: begin
            next_rdata[CNT_WIDTH-1:0] = count;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // apb answer: one wait-free access phase after each setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= setup;
      end
   end

   // read data and error are captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata <= pwrite ? 32'h0000_0000 : next_rdata;
         pslverr <= !hit;
      end
   end

   // ==========================================================
   // pending control: applied only by a valid feed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_sel <= RST_SEL;
         pend_run <= RST_RUN;
      end else if (wr && paddr == ADDR_CTRL) begin
         pend_sel <= pwdata[CTRL_SEL_LSB +: SEL_WIDTH]; // R13
         pend_run <= pwdata[CTRL_RUN_BIT]; // R13 R14
      end
   end

   // active control; a watchdog reset leaves it alone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_sel <= RST_SEL; // R17
         run_bit <= RST_RUN; // R1 R17
      end else if (feed_ok) begin
         act_sel <= pend_sel; // R13
         run_bit <= pend_run; // R13
      end
   end

   // ==========================================================
   // autoload value, any byte allowed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         autoload_reg <= RST_AUTOLOAD; // R17
      end else if (wr && paddr == ADDR_AUTOLOAD) begin
         autoload_reg <= pwdata[CNT_WIDTH-1:0]; // R7
      end
   end

   // ==========================================================
   // main counter: only autoload or decrement touch it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= RST_AUTOLOAD; // R17
      end else if (load) begin
         count <= autoload_reg; // R6 R9 R18
      end else if (dec) begin
         count <= count - 1'b1; // R8 R3
      end
   end

   // ==========================================================
   // timeout flag: set wins over a software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timeout_flag <= 1'b0; // R17
      end else if (wd_event) begin
         timeout_flag <= 1'b1; // R18 R19
      end else if (flag_clr) begin
         timeout_flag <= 1'b0; // R19
      end
   end

   // reset request to the system reset block
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_reset_req <= 1'b0;
      end else begin
         sys_reset_req <= wd_event; // R2
      end
   end

   // ==========================================================
   // checks
   // helper for the checks: the last completed access carried the first key;
   // it only watches the bus, so a slip in the feed state machine shows up
   // here instead of being mirrored by the check
   logic last_key1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_key1 <= 1'b0;
      end else if (acc) begin
         last_key1 <= pwrite && paddr == ADDR_FEED1 && pwdata[7:0] == FEED1_KEY;
      end
   end

   // all checks run on the bus clock and sleep through the async reset
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // feed: settings, reload and the order of the two keys
   feed_apply_a: assert property (feed_ok |=> run_bit == $past(pend_run) // R13
      && act_sel == $past(pend_sel) && count == $past(autoload_reg))
      else $error("feed did not apply settings");

   feed_key_a: assert property (feed_ok |-> $past(wr) == 1'b0 && wr // R10
      && pwdata[7:0] == FEED2_KEY && paddr == ADDR_FEED2)
      else $error("feed accepted without second key");

   feed_order_a: assert property (feed_ok || feed_fail |-> last_key1) // R10 R11
      else $error("feed judged without a first key");

   pending_hold_a: assert property (!feed_ok |=> $stable(run_bit) // R13
      && $stable(act_sel))
      else $error("control changed without a feed");

   // failed feeds and underflow both end in a reset request
   fail_reset_a: assert property (feed_fail |=> sys_reset_req // R11
      && timeout_flag)
      else $error("failed feed gave no reset");

   bad_key_a: assert property (feed_fail && pwrite && paddr == ADDR_FEED2 // R12
      |=> sys_reset_req ##1 !sys_reset_req)
      else $error("wrong second key gave no reset");

   underflow_load_a: assert property (underflow |=> sys_reset_req // R6
      && count == $past(autoload_reg) && pre_count == '0)
      else $error("underflow did not reload");

   keep_setup_a: assert property (wd_event && !feed_ok |=> // R18
      $stable(autoload_reg) && $stable(act_sel) && $stable(run_bit))
      else $error("watchdog reset changed settings");

   flag_set_a: assert property (wd_event |=> timeout_flag && sys_reset_req) // R18
      else $error("watchdog reset left the flag clear");

   // counter and prescaler movement
   count_path_a: assert property ($changed(count) |-> // R9
      $past(dec) || $past(load))
      else $error("counter changed without cause");

   count_step_a: assert property (dec && !load |=> // R8
      count == $past(count) - 8'h01)
      else $error("counter did not step by one");

   fast_tap_a: assert property (dec |-> pre_count[4:0] == 5'h1f) // R5
      else $error("decrement before 32 ticks");

   feed_clear_a: assert property (load |=> pre_count == '0) // R7
      else $error("autoload kept the prescaler count");

   // a stopped watchdog must neither count nor underflow
   stopped_a: assert property (!run_bit |-> !dec // R20
      && !underflow)
      else $error("stopped watchdog counted");

   stopped_hold_a: assert property (!run_bit && !load |=> // R20
      $stable(pre_count) && $stable(count))
      else $error("stopped watchdog moved");

   // timeout flag: survives a watchdog reset until software clears it,
   // and a clear that meets a new event in one cycle loses
   flag_keep_a: assert property (timeout_flag && !flag_clr // R19
      |=> timeout_flag)
      else $error("timeout flag lost");

   flag_clear_a: assert property (flag_clr && !wd_event |=> !timeout_flag) // R19
      else $error("software clear of the flag ignored");

   // main scenarios that must be reached at least once
   feed_seen_c: cover property (feed_ok);
   feed_bad_c: cover property (feed_fail);
   underflow_c: cover property (underflow);
   stop_c: cover property (feed_ok && !pend_run);
   flag_clr_c: cover property (flag_clr && timeout_flag);
endmodule // wdpa_top
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for the prescaled autoload watchdog
// Assumes: apb slave answers on its own pready; tick is a one-cycle enable
// Notes:   a reference model runs beside the design and is compared each cycle
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import wdpa_pkg::*;
   // ==========================================================
   // stimulus and observed signals
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic        timer_tick_clock = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        sys_reset_req;
   logic        timeout_flag;
   integer      seed = 32'he924b3e7;
   int          err_total = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   int          tmode = 0;
   logic        quiet = 1'b0;
   logic [7:0]  w8;
   // reference state
   logic        m_run, p_run, m_flag, m_arm, m_rst;
   logic [2:0]  m_sel, p_sel;
   logic [7:0]  m_al, m_cnt;
   logic [12:0] m_pre;

   wdpa_top u_wdpa_top (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .timer_tick_clock(timer_tick_clock),
      .sys_reset_req(sys_reset_req), .timeout_flag(timeout_flag));

   always #20 pclk = ~pclk;

   // ticks pause around reads so the read value cannot move under the access
   always @(posedge pclk) begin
      timer_tick_clock <= !quiet && (tmode == 1 || (tmode == 2 && $random(seed) % 2 == 0));
   end

   // ==========================================================
   // reference model
   always @(posedge pclk or negedge presetn) begin : ref_model
      logic [12:0] pr, mask;
      logic [7:0]  c, d;
      logic        fl, ld, rs, acc;
      if (!presetn) begin
         m_run <= 1'b1; p_run <= 1'b1; m_sel <= 3'h7; p_sel <= 3'h7;
         m_al <= 8'h00; m_cnt <= 8'h00; m_pre <= 13'h0;
         m_flag <= 1'b0; m_arm <= 1'b0; m_rst <= 1'b0;
      end else begin
         pr = m_pre; c = m_cnt; fl = m_flag; ld = 1'b0; rs = 1'b0; d = pwdata[7:0];
         acc = psel && penable && pready;
         if (acc && pwrite && paddr == ADDR_CTRL) begin
            p_sel <= d[7:5]; p_run <= d[2];
            if (!d[1]) fl = 1'b0;
         end
         if (acc && pwrite && paddr == ADDR_AUTOLOAD) m_al <= d;
         mask = (13'h1 << ({1'b0, m_sel} + 4'd5)) - 13'h1;
         if (m_run && timer_tick_clock) begin
            if ((pr & mask) == mask) begin
               if (c == 8'h00) begin ld = 1'b1; rs = 1'b1; end
               else c = c - 8'h01;
            end
            pr = pr + 13'h1;
         end
         if (acc && m_arm) begin
            ld = 1'b1;
            if (pwrite && paddr == ADDR_FEED2 && d == FEED2_KEY) begin
               m_run <= p_run; m_sel <= p_sel;
            end else rs = 1'b1;
         end
         m_arm <= acc ? (!m_arm && pwrite && paddr == ADDR_FEED1 && d == FEED1_KEY) : m_arm;
         if (ld) begin c = m_al; pr = 13'h0; end
         if (rs) fl = 1'b1;
         m_cnt <= c; m_pre <= pr; m_flag <= fl; m_rst <= rs;
      end
   end

   // ==========================================================
   // compare tasks and bus access
   task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] s);
      samples_checked++;
      if (s !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask

   always @(negedge pclk) begin
      if (presetn) begin
         chk_w("sys_reset_req", {31'h0, m_rst}, {31'h0, sys_reset_req});
         chk_w("timeout_flag", {31'h0, m_flag}, {31'h0, timeout_flag});
      end
   end

   function automatic logic [32:0] exp_rd(input logic [7:0] a);
      case (a)
         ADDR_CTRL:     return {1'b0, 24'h0, m_sel, 2'b00, m_run, m_flag, 1'b0};
         ADDR_AUTOLOAD: return {25'h0, m_al};
         ADDR_COUNT:    return {25'h0, m_cnt};
         ADDR_FEED1, ADDR_FEED2: return 33'h0;
         default:       return {1'b1, 32'h0};
      endcase
   endfunction

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      logic [32:0] e;
      int          n;
      n = 0;
      if (!w) begin
         @(posedge pclk);
         quiet <= 1'b1;
      end
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      e = exp_rd(a);
      if (!w) chk_w("prdata", e[31:0], prdata);
      chk_w("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
      if (n >= 20) chk_w("pready", 32'h1, 32'h0);
      psel <= 1'b0; penable <= 1'b0; quiet <= 1'b0;
   endtask

   task automatic feed();
      apb(1'b1, ADDR_FEED1, {24'h0, FEED1_KEY});
      apb(1'b1, ADDR_FEED2, {24'h0, FEED2_KEY});
   endtask

   task automatic wait_rst(input int maxc);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (sys_reset_req !== 1'b1 && n < maxc);
      if (n >= maxc) chk_w("reset pulse", 32'h1, 32'h0);
   endtask

   task automatic do_reset();
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // hang guard well above the expected run of at most about 54k cycles
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         err_total++;
         wrap_up();
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      do_reset();
      apb(1'b0, ADDR_CTRL, 32'h0);
      apb(1'b0, ADDR_AUTOLOAD, 32'h0);
      apb(1'b0, ADDR_COUNT, 32'h0);
      apb(1'b0, ADDR_FEED1, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      apb(1'b1, 8'h20, 32'h1);
      tmode = 1;
      wait_rst(4200);
      apb(1'b0, ADDR_CTRL, 32'h0);
      apb(1'b1, ADDR_CTRL, 32'he4);
      apb(1'b0, ADDR_CTRL, 32'h0);
      // every divisor code, widest reload on the fastest tap
      for (int s = 0; s < 8; s++) begin
         w8 = (s == 0) ? 8'hff : 8'($random(seed) & 3);
         apb(1'b1, ADDR_AUTOLOAD, {24'h0, w8});
         apb(1'b1, ADDR_CTRL, {24'h0, 3'(s), 5'h04});
         apb(1'b0, ADDR_CTRL, 32'h0);
         feed();
         apb(1'b0, ADDR_CTRL, 32'h0);
         wait_rst(((int'(w8) + 1) << (s + 5)) + 40);
      end
      tmode = 2;
      apb(1'b1, ADDR_COUNT, $random(seed));
      apb(1'b0, ADDR_COUNT, 32'h0);
      apb(1'b1, ADDR_CTRL, 32'h0);
      feed();
      repeat (9000) @(posedge pclk);
      apb(1'b0, ADDR_COUNT, 32'h0);
      apb(1'b1, ADDR_FEED1, 32'h33);
      apb(1'b1, ADDR_FEED2, {24'h0, FEED2_KEY});
      apb(1'b1, ADDR_FEED1, {24'h0, FEED1_KEY});
      apb(1'b1, ADDR_FEED2, 32'h5b);
      wait_rst(10);
      apb(1'b1, ADDR_FEED1, {24'h0, FEED1_KEY});
      apb(1'b0, ADDR_CTRL, 32'h0);
      wait_rst(10);
      apb(1'b1, ADDR_FEED1, {24'h0, FEED1_KEY});
      apb(1'b1, ADDR_FEED1, {24'h0, FEED1_KEY});
      wait_rst(10);
      apb(1'b1, ADDR_CTRL, 32'he4);
      feed();
      do_reset();
      apb(1'b0, ADDR_CTRL, 32'h0);
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
